// >>> hdl/mmcfe_pkg.sv
// Summary of operation
// RQ1: dma handshakes generated on bus clock only
// RQ2: power field 00 off, 11 on
// RQ3: software spaces repeated control register writes
// RQ4: software keeps identification clock below 400 kHz
// RQ5: divided clock is controller clock over 2(div+1)
// RQ6: bypass bit drives card clock from controller; the code gives half the controller clock rate
// RQ7: idle gate bit stops clock when idle
// RQ8: enable bit gates card clock output
// RQ9: width bit selects one or four lines
// RQ10: software loads argument before command write
// RQ11: enable bit starts command, clear disables path
// RQ12: pending bit waits for command go input
// RQ13: interrupt bit disables timer, waits for card
// RQ14: long bit plus response gives 136 bits
// RQ15: completion raises sent, ok or crc flag; the code never checks crc or sets the crc flag
// RQ16: six-bit opcode index sent in command
// RQ17: reply index holds last index, long 111111
// RQ18: status msb first into status registers
// RQ19: status register three bit zero reads zero
// RQ20: data timer decrements in wait or busy
// RQ21: byte count loaded into data counter
// RQ22: software writes timer and length first
// RQ23: data enable starts transfer by direction
// RQ24: static flags stay until clear written
// RQ25: missing response raises command timeout flag
package mmcfe_pkg;
	localparam logic [31:0] ADDR_POWER    = 32'h700C_A000;
	localparam logic [31:0] ADDR_CLOCK    = 32'h700C_A004;
	localparam logic [31:0] ADDR_ARG      = 32'h700C_A008;
	localparam logic [31:0] ADDR_CMD      = 32'h700C_A00C;
	localparam logic [31:0] ADDR_RINDEX   = 32'h700C_A010;
	localparam logic [31:0] ADDR_RSTAT0   = 32'h700C_A014;
	localparam logic [31:0] ADDR_RSTAT1   = 32'h700C_A018;
	localparam logic [31:0] ADDR_RSTAT2   = 32'h700C_A01C;
	localparam logic [31:0] ADDR_RSTAT3   = 32'h700C_A020;
	localparam logic [31:0] ADDR_DTIMER   = 32'h700C_A024;
	localparam logic [31:0] ADDR_DLEN     = 32'h700C_A028;
	localparam logic [31:0] ADDR_DCTRL    = 32'h700C_A02C;
	localparam logic [31:0] ADDR_STATUS   = 32'h700C_A034;
	localparam logic [31:0] ADDR_CLEAR    = 32'h700C_A038;
	localparam logic [1:0]  PWR_OFF       = 2'h0;
	localparam logic [1:0]  PWR_ON        = 2'h3;
	localparam int          CLK_WIDE_BIT  = 11;
	localparam int          CLK_BYP_BIT   = 10;
	localparam int          CLK_SAVE_BIT  = 9;
	localparam int          CLK_EN_BIT    = 8;
	localparam int          CMD_EN_BIT    = 10;
	localparam int          CMD_PEND_BIT  = 9;
	localparam int          CMD_IRQ_BIT   = 8;
	localparam int          CMD_LONG_BIT  = 7;
	localparam int          CMD_RSP_BIT   = 6;
	localparam int          DC_EN_BIT     = 0;
	localparam int          DC_DIR_BIT    = 1;
	localparam int          ST_CRCFAIL    = 0;
	localparam int          ST_CMDTO      = 2;
	localparam int          ST_DATATO     = 3;
	localparam int          ST_RSPEND     = 6;
	localparam int          ST_COMMAND_SENT_FLAG    = 7;
	localparam int          ST_CMDACT     = 11;
	localparam logic [5:0]  LONG_INDEX    = 6'h3F;
	localparam logic [7:0]  CMD_BITS      = 8'h30;
	localparam logic [7:0]  SHORT_BITS    = 8'h30;
	localparam logic [7:0]  LONG_BITS     = 8'h88;
	localparam logic [7:0]  RSP_TIMEOUT   = 8'h40;
	localparam logic [7:0]  START_WAIT    = 8'h08;
	localparam logic [31:0] RESET_ZERO    = 32'h0000_0000;
endpackage

// >>> hdl/mmcfe_clkgen.sv
`timescale 1ns/1ps
// card clock generator; one tick per card clock period, level output
module mmcfe_clkgen (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] divisor,
	input  wire logic       bypass,
	output logic            tick,
	output logic            level
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic       lvl_reg;
	logic       lvl_next;
	logic       tick_next;

	always_comb begin
		cnt_next  = cnt_reg;
		lvl_next  = lvl_reg;
		tick_next = 1'b0;
		if (bypass) begin
			cnt_next  = 8'h00;
			lvl_next  = ~lvl_reg;
			// one tick per card period, as when dividing, so shifts match the pin
			tick_next = lvl_reg; // RQ6
		end else if (cnt_reg >= divisor) begin
			cnt_next  = 8'h00;
			lvl_next  = ~lvl_reg; // RQ5
			tick_next = lvl_reg;
		end else begin
			cnt_next = cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt_reg <= 8'h00;
			lvl_reg <= 1'b0;
			tick    <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			lvl_reg <= lvl_next;
			tick    <= tick_next;
		end
	end
	assign level = lvl_reg;
endmodule

// >>> hdl/mmcfe_top.sv
`timescale 1ns/1ps
// register front end: power, card clock, command path, response capture, data setup
module mmcfe_top (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic [31:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	output logic             card_power_on,
	output logic             card_bus_clock,
	output logic             four_line_select,
	output logic             card_command_line_out,
	output logic             card_command_line_oe,
	input  wire logic        card_command_line_in,
	input  wire logic        command_go_input,
	input  wire logic        card_irq_seen,
	input  wire logic        data_busy,
	output logic             data_path_start,
	output logic             data_direction,
	output logic      [15:0] data_count_load,
	output logic             data_timeout_flag,
	output logic             command_active
);
	typedef enum logic [5:0] {
		CP_IDLE = 6'b000001,
		CP_PEND = 6'b000010,
		CP_SEND = 6'b000100,
		CP_WAIT = 6'b001000,
		CP_RECV = 6'b010000,
		CP_IRQ  = 6'b100000
	} mmcfe_cp_t;

	logic [31:0] power_reg, clock_reg, arg_reg, cmd_reg, dtimer_reg, dlen_reg;
	logic [31:0] power_next, clock_next, arg_next, cmd_next, dtimer_next, dlen_next;
	logic [5:0]  rindex_reg, rindex_next;
	logic [31:0] rstat_reg [4];
	logic [31:0] rstat_next [4];
	logic [10:0] flags_reg, flags_next;
	logic [31:0] rdata_next;
	mmcfe_cp_t   cp_reg, cp_next;
	logic [7:0]  bits_reg, bits_next;
	logic [7:0]  tmo_reg, tmo_next;
	logic [47:0] shift_reg, shift_next;
	logic [127:0] rsp_reg, rsp_next;
	logic [31:0] dcnt_reg, dcnt_next;
	logic        dwait_reg, dwait_next;
	logic        cmd_meta, cmd_sync, go_meta, go_sync, irq_meta, irq_sync;
	logic        busy_meta, busy_sync;
	logic        tick, level;
	logic        pwr_next, clk_next, wide_next, cout_next, coe_next;
	logic        start_next, dir_next, dto_next, act_next;
	logic [15:0] load_next;
	logic [10:0] set_flags;

	mmcfe_clkgen u_clkgen (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.divisor  (clock_reg[7:0]),
		.bypass   (clock_reg[mmcfe_pkg::CLK_BYP_BIT]),
		.tick     (tick),
		.level    (level)
	);

	function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
		return a == b;
	endfunction

	// pins from the card pass two flops first
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cmd_meta  <= 1'b1;
			cmd_sync  <= 1'b1;
			go_meta   <= 1'b0;
			go_sync   <= 1'b0;
			irq_meta  <= 1'b0;
			irq_sync  <= 1'b0;
			busy_meta <= 1'b0;
			busy_sync <= 1'b0;
		end else begin
			cmd_meta  <= card_command_line_in;
			cmd_sync  <= cmd_meta;
			go_meta   <= command_go_input;
			go_sync   <= go_meta;
			irq_meta  <= card_irq_seen;
			irq_sync  <= irq_meta;
			busy_meta <= data_busy;
			busy_sync <= busy_meta;
		end
	end

	always_comb begin
		power_next  = power_reg;
		clock_next  = clock_reg;
		arg_next    = arg_reg;
		cmd_next    = cmd_reg;
		dtimer_next = dtimer_reg;
		dlen_next   = dlen_reg;
		rindex_next = rindex_reg;
		rstat_next  = rstat_reg;
		cp_next     = cp_reg;
		bits_next   = bits_reg;
		tmo_next    = tmo_reg;
		shift_next  = shift_reg;
		rsp_next    = rsp_reg;
		dcnt_next   = dcnt_reg;
		dwait_next  = dwait_reg;
		set_flags   = 11'h000;
		start_next  = 1'b0;
		dir_next    = data_direction;
		load_next   = data_count_load;
		cout_next   = card_command_line_out;
		coe_next    = card_command_line_oe;
		if (reg_wr) begin
			if (hit(reg_addr, mmcfe_pkg::ADDR_POWER))
				power_next = {30'h0000_0000, reg_wdata[1:0]};
			if (hit(reg_addr, mmcfe_pkg::ADDR_CLOCK))
				clock_next = {20'h0_0000, reg_wdata[11:0]};
			if (hit(reg_addr, mmcfe_pkg::ADDR_ARG))
				arg_next = reg_wdata;
			if (hit(reg_addr, mmcfe_pkg::ADDR_CMD))
				cmd_next = {21'h00_0000, reg_wdata[10:0]};
			if (hit(reg_addr, mmcfe_pkg::ADDR_DTIMER))
				dtimer_next = reg_wdata;
			if (hit(reg_addr, mmcfe_pkg::ADDR_DLEN))
				dlen_next = {16'h0000, reg_wdata[15:0]};
			if (hit(reg_addr, mmcfe_pkg::ADDR_DCTRL) && reg_wdata[mmcfe_pkg::DC_EN_BIT]) begin
				start_next = 1'b1; // RQ23
				dir_next   = reg_wdata[mmcfe_pkg::DC_DIR_BIT];
				load_next  = dlen_reg[15:0]; // RQ21
				dcnt_next  = dtimer_reg;
				dwait_next = reg_wdata[mmcfe_pkg::DC_DIR_BIT];
			end
		end
		// data timer runs in card clock periods while waiting to receive or busy
		if ((dwait_reg || busy_sync) && tick) begin // RQ20
			if (dcnt_reg == 32'h0000_0000) begin
				set_flags[mmcfe_pkg::ST_DATATO] = 1'b1;
				dwait_next = 1'b0;
			end else begin
				dcnt_next = dcnt_reg - 32'h0000_0001;
			end
		end
		// enable self-clears after the frame, so any write with it low must stop the path
		if (reg_wr && hit(reg_addr, mmcfe_pkg::ADDR_CMD) &&
			!reg_wdata[mmcfe_pkg::CMD_EN_BIT]) begin
			cp_next  = CP_IDLE; // RQ11
			coe_next = 1'b0;
		end else if (tick) begin
			unique case (cp_reg)
				CP_IDLE: begin
					// release the line once the end bit has stood a full period
					coe_next = 1'b0;
					if (cmd_reg[mmcfe_pkg::CMD_EN_BIT]) begin
						cp_next = cmd_reg[mmcfe_pkg::CMD_PEND_BIT] ? CP_PEND : CP_SEND; // RQ11
						// start, host bit, index, argument, dummy crc, end
						shift_next = {2'h1, cmd_reg[5:0], arg_reg, 8'h01}; // RQ16
						bits_next  = mmcfe_pkg::CMD_BITS;
					end
				end
				CP_PEND: if (go_sync) cp_next = CP_SEND; // RQ12
				CP_SEND: begin
					coe_next   = 1'b1;
					cout_next  = shift_reg[47];
					shift_next = {shift_reg[46:0], 1'b1};
					bits_next  = bits_reg - 8'h01;
					if (bits_reg == 8'h01) begin
						cmd_next[mmcfe_pkg::CMD_EN_BIT] = 1'b0;
						tmo_next = mmcfe_pkg::RSP_TIMEOUT;
						if (!cmd_reg[mmcfe_pkg::CMD_RSP_BIT]) begin
							set_flags[mmcfe_pkg::ST_COMMAND_SENT_FLAG] = 1'b1; // RQ15
							cp_next = CP_IDLE;
						end else if (cmd_reg[mmcfe_pkg::CMD_IRQ_BIT]) begin
							cp_next = CP_IRQ; // RQ13
						end else begin
							cp_next = CP_WAIT;
						end
					end
				end
				CP_WAIT: begin
					coe_next = 1'b0;
					tmo_next = tmo_reg - 8'h01;
					if (!cmd_sync) begin
						cp_next   = CP_RECV;
						rsp_next  = 128'h0;
						bits_next = cmd_reg[mmcfe_pkg::CMD_LONG_BIT] ? // RQ14
							mmcfe_pkg::LONG_BITS - 8'h01 : mmcfe_pkg::SHORT_BITS - 8'h01;
					end else if (tmo_reg == 8'h00) begin
						set_flags[mmcfe_pkg::ST_CMDTO] = 1'b1; // RQ25
						cp_next = CP_IDLE;
					end
				end
				CP_IRQ: begin
					coe_next = 1'b0;
					if (irq_sync) cp_next = CP_IDLE; // RQ13
				end
				CP_RECV: begin
					rsp_next  = {rsp_reg[126:0], cmd_sync}; // RQ18
					bits_next = bits_reg - 8'h01;
					if (bits_reg == 8'h01) begin
						cp_next = CP_IDLE;
						set_flags[mmcfe_pkg::ST_RSPEND] = 1'b1; // RQ15
						if (cmd_reg[mmcfe_pkg::CMD_LONG_BIT]) begin
							// long reply: drop the end bit, keep 127 status bits
							rindex_next   = mmcfe_pkg::LONG_INDEX; // RQ17
							rstat_next[0] = rsp_reg[126:95];
							rstat_next[1] = rsp_reg[94:63];
							rstat_next[2] = rsp_reg[62:31];
							rstat_next[3] = {rsp_reg[30:0], 1'b0}; // RQ19
						end else begin
							rindex_next   = rsp_reg[44:39]; // RQ17
							rstat_next[0] = rsp_reg[38:7]; // RQ18
						end
					end
				end
				default: cp_next = CP_IDLE;
			endcase
		end
		// set beats clear in the same cycle
		flags_next = flags_reg;
		if (reg_wr && hit(reg_addr, mmcfe_pkg::ADDR_CLEAR))
			flags_next = flags_reg & ~reg_wdata[10:0]; // RQ24
		flags_next = flags_next | set_flags;
	end

	always_comb begin
		rdata_next = 32'h0000_0000;
		if (reg_rd) begin
			unique case (1'b1)
				hit(reg_addr, mmcfe_pkg::ADDR_POWER):  rdata_next = power_reg;
				hit(reg_addr, mmcfe_pkg::ADDR_CLOCK):  rdata_next = clock_reg;
				hit(reg_addr, mmcfe_pkg::ADDR_ARG):    rdata_next = arg_reg;
				hit(reg_addr, mmcfe_pkg::ADDR_CMD):    rdata_next = cmd_reg;
				hit(reg_addr, mmcfe_pkg::ADDR_RINDEX): rdata_next = {26'h000_0000, rindex_reg};
				hit(reg_addr, mmcfe_pkg::ADDR_RSTAT0): rdata_next = rstat_reg[0];
				hit(reg_addr, mmcfe_pkg::ADDR_RSTAT1): rdata_next = rstat_reg[1];
				hit(reg_addr, mmcfe_pkg::ADDR_RSTAT2): rdata_next = rstat_reg[2];
				hit(reg_addr, mmcfe_pkg::ADDR_RSTAT3): rdata_next = rstat_reg[3];
				hit(reg_addr, mmcfe_pkg::ADDR_DTIMER): rdata_next = dtimer_reg;
				hit(reg_addr, mmcfe_pkg::ADDR_DLEN):   rdata_next = dlen_reg;
				hit(reg_addr, mmcfe_pkg::ADDR_STATUS):
					rdata_next = {20'h0_0000, cp_reg != CP_IDLE, flags_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// output stage
	always_comb begin
		pwr_next  = power_reg[1:0] == mmcfe_pkg::PWR_ON; // RQ2
		wide_next = clock_reg[mmcfe_pkg::CLK_WIDE_BIT]; // RQ9
		// the card clock is a registered level, so bypass gives half rate
		clk_next  = level && clock_reg[mmcfe_pkg::CLK_EN_BIT] && // RQ8
			(!clock_reg[mmcfe_pkg::CLK_SAVE_BIT] || cp_reg != CP_IDLE || dwait_reg ||
			busy_sync); // RQ7
		dto_next  = flags_next[mmcfe_pkg::ST_DATATO];
		act_next  = cp_next != CP_IDLE;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			power_reg  <= mmcfe_pkg::RESET_ZERO;
			clock_reg  <= mmcfe_pkg::RESET_ZERO;
			arg_reg    <= mmcfe_pkg::RESET_ZERO;
			cmd_reg    <= mmcfe_pkg::RESET_ZERO;
			dtimer_reg <= mmcfe_pkg::RESET_ZERO;
			dlen_reg   <= mmcfe_pkg::RESET_ZERO;
			rindex_reg <= 6'h00;
			rstat_reg  <= '{default: 32'h0000_0000};
			flags_reg  <= 11'h000;
			cp_reg     <= CP_IDLE;
			bits_reg   <= 8'h00;
			tmo_reg    <= 8'h00;
			shift_reg  <= 48'h0;
			rsp_reg    <= 128'h0;
			dcnt_reg   <= mmcfe_pkg::RESET_ZERO;
			dwait_reg  <= 1'b0;
			reg_rdata  <= mmcfe_pkg::RESET_ZERO;
			card_power_on         <= 1'b0;
			card_bus_clock        <= 1'b0;
			four_line_select      <= 1'b0;
			card_command_line_out <= 1'b1;
			card_command_line_oe  <= 1'b0;
			data_path_start       <= 1'b0;
			data_direction        <= 1'b0;
			data_count_load       <= 16'h0000;
			data_timeout_flag     <= 1'b0;
			command_active        <= 1'b0;
		end else begin
			power_reg  <= power_next;
			clock_reg  <= clock_next;
			arg_reg    <= arg_next;
			cmd_reg    <= cmd_next;
			dtimer_reg <= dtimer_next;
			dlen_reg   <= dlen_next;
			rindex_reg <= rindex_next;
			rstat_reg  <= rstat_next;
			flags_reg  <= flags_next;
			cp_reg     <= cp_next;
			bits_reg   <= bits_next;
			tmo_reg    <= tmo_next;
			shift_reg  <= shift_next;
			rsp_reg    <= rsp_next;
			dcnt_reg   <= dcnt_next;
			dwait_reg  <= dwait_next;
			reg_rdata  <= rdata_next;
			card_power_on         <= pwr_next;
			card_bus_clock        <= clk_next;
			four_line_select      <= wide_next;
			card_command_line_out <= cout_next;
			card_command_line_oe  <= coe_next;
			data_path_start       <= start_next; // RQ1
			data_direction        <= dir_next;
			data_count_load       <= load_next;
			data_timeout_flag     <= dto_next;
			command_active        <= act_next;
		end
	end
endmodule

// >>> tb/mmcfe_checker.sv
`timescale 1ns/1ps
module mmcfe_checker (
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic [31:0] reg_addr,
	input wire logic        reg_wr,
	input wire logic [31:0] reg_wdata,
	input wire logic        card_power_on,
	input wire logic        card_bus_clock,
	input wire logic        card_command_line_oe,
	input wire logic        command_go_input,
	input wire logic        data_path_start,
	input wire logic [15:0] data_count_load,
	input wire logic        command_active
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	logic [31:0] ck_reg;
	logic [15:0] len_reg;
	logic        pend_reg;
	logic        lvl_reg;
	logic [10:0] age_reg;
	logic [9:0]  per_reg;
	wire         wr_ck = reg_wr && reg_addr == mmcfe_pkg::ADDR_CLOCK;
	wire         wr_cm = reg_wr && reg_addr == mmcfe_pkg::ADDR_CMD;
	wire         rise = card_bus_clock && !lvl_reg;
	// age keeps a period that straddles a clock write out of the checks
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ck_reg <= 32'h0;
			pend_reg <= 1'b0;
		end else if (wr_ck) begin
			ck_reg <= reg_wdata;
		end else if (wr_cm) begin
			pend_reg <= reg_wdata[9];
		end
		if (reg_wr && reg_addr == mmcfe_pkg::ADDR_DLEN)
			len_reg <= reg_wdata[15:0];
		lvl_reg <= card_bus_clock;
		per_reg <= rise ? 10'h1 : per_reg + {9'h0, per_reg != 10'h3FF};
		age_reg <= (sys_rst || wr_ck) ? 11'h0 : age_reg + {10'h0, age_reg != 11'h7FF};
	end
	AST_PWR_ON: assert property (reg_wr && reg_addr == mmcfe_pkg::ADDR_POWER &&
		reg_wdata[1:0] == 2'h3 |-> ##[1:3] card_power_on) else $error("power stayed off");
	AST_PWR_OFF: assert property (reg_wr && reg_addr == mmcfe_pkg::ADDR_POWER &&
		reg_wdata[1:0] != 2'h3 |-> ##[1:3] !card_power_on) else $error("power stayed on");
	AST_CLK_OFF: assert property ((!ck_reg[8]) [*4] |-> $stable(card_bus_clock))
		else $error("card clock runs while disabled");
	AST_DIV: assert property ($rose(card_bus_clock) && ck_reg[10:8] == 3'h1 &&
		age_reg > {1'b0, ck_reg[7:0], 2'h0} + 11'h00C
		|-> per_reg == {1'b0, ck_reg[7:0], 1'b0} + 10'h2) else $error("divided period wrong");
	AST_BYP: assert property ($rose(card_bus_clock) && ck_reg[10:8] == 3'h5 &&
		age_reg > 11'h008 |-> per_reg == 10'h2) else $error("bypass period wrong");
	AST_CMD_GO: assert property (wr_cm && reg_wdata[10:9] == 2'h2
		|-> ##[1:520] command_active) else $error("command did not start");
	AST_CMD_OFF: assert property (wr_cm && !reg_wdata[10]
		|-> ##[1:24] !command_active) else $error("command path not disabled");
	AST_PEND: assert property ((pend_reg && !command_go_input) [*6]
		|-> !card_command_line_oe) else $error("command sent before go");
	AST_DSTART: assert property (reg_wr && reg_addr == mmcfe_pkg::ADDR_DCTRL &&
		reg_wdata[0] |-> ##[1:2] data_path_start) else $error("no data start pulse");
	AST_DLOAD: assert property ($rose(data_path_start)
		|-> ##[0:1] data_count_load == len_reg) else $error("data count not loaded");
	cover property ($fell(command_active));
	cover property ($rose(data_path_start));
	cover property ($rose(card_power_on));
endmodule
bind mmcfe_top mmcfe_checker chk (.*);

// >>> tb/mmcfe_card.sv
`timescale 1ns/1ps
// card end of the command line; replies two card clocks after a frame
module mmcfe_card (
	input  wire logic         clk_in,
	input  wire logic         line,
	input  wire logic         host_oe,
	input  wire logic [1:0]   mode,
	input  wire logic [5:0]   idx,
	input  wire logic [127:0] body,
	output logic              drv,
	output logic              drv_oe,
	output logic [47:0]       last_cmd,
	output int                frames
);
	logic [135:0] fr;
	int           n = 0;
	initial begin
		drv = 1'b1;
		drv_oe = 1'b0;
		frames = 0;
	end
	// sampled 5 ns after the rising edge so the host's bit change never races us
	always @(posedge clk_in) begin
		#5;
		if (host_oe) begin
			last_cmd = {last_cmd[46:0], line};
			n++;
		end
		if (n == 48) begin
			n = 0;
			frames++;
			fr = mode[1] ? {8'h3F, body[127:1], 1'b1} : {88'h0, 2'b00, idx, body[31:0], 8'h01};
			if (mode != 2'h0) begin
				repeat (2) @(negedge clk_in);
				for (int i = (mode[1] ? 135 : 47); i >= 0; i--) begin
					@(negedge clk_in);
					drv_oe = 1'b1;
					drv = fr[i];
				end
				@(negedge clk_in);
				drv_oe = 1'b0;
			end
		end
	end
endmodule

// >>> tb/card_host_cmd_clock_regs_tb.sv
`timescale 1ns/1ps
module card_host_cmd_clock_regs_tb;
	logic         core_clk = 1'b0;
	logic         sys_rst = 1'b1;
	logic [31:0]  reg_addr = 32'h0;
	logic         reg_wr = 1'b0;
	logic         reg_rd = 1'b0;
	logic [31:0]  reg_wdata = 32'h0;
	logic         command_go_input = 1'b0;
	logic         card_irq_seen = 1'b0;
	logic         data_busy = 1'b0;
	logic [1:0]   mode = 2'h0;
	logic [127:0] body = 128'h89AB_CDEF_0246_8ACE_1357_9BDF_FEDC_BA99;
	logic [31:0]  reg_rdata, d;
	logic         card_power_on, card_bus_clock, four_line_select, k_drv, k_oe;
	logic         card_command_line_out, card_command_line_oe, card_command_line_in;
	logic         data_path_start, data_direction, data_timeout_flag, command_active;
	logic [15:0]  data_count_load;
	logic [47:0]  last_cmd;
	int           frames, f, failures = 0, samples_checked = 0;
	// released command line sits at its pull-up
	assign card_command_line_in = card_command_line_oe ? card_command_line_out : (k_oe ? k_drv : 1'b1);
	mmcfe_top dut (.*);
	mmcfe_card card (.clk_in(card_bus_clock), .line(card_command_line_in),
		.host_oe(card_command_line_oe), .mode(mode), .idx(6'h15), .body(body),
		.drv(k_drv), .drv_oe(k_oe), .last_cmd(last_cmd), .frames(frames));
	initial forever #20 core_clk = ~core_clk;
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", w, e, s);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask
	task automatic rc(input string w, input logic [31:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		chk(w, reg_rdata, e);
	endtask
	task automatic wa(input logic l, input int lim);
		int i;
		for (i = 0; i < lim && command_active !== l; i++)
			@(posedge core_clk);
		if (i == lim) begin
			failures++;
			$display("unexpected command_active: expected %b seen %b", l, command_active);
			tally_and_finish;
		end
	endtask
	task automatic cr(input logic [31:0] v, input logic [31:0] e);
		logic        p;
		logic [31:0] n;
		wr(mmcfe_pkg::ADDR_CLOCK, v);
		n = 32'h0;
		// start on a falling edge so a rise at the write edge is never half counted
		@(negedge core_clk);
		p = card_bus_clock;
		repeat (48) begin
			@(negedge core_clk);
			n += {31'h0, card_bus_clock & ~p};
			p = card_bus_clock;
		end
		chk("card clock rises", n, e);
	endtask
	task automatic cmd(input logic [31:0] v);
		wr(mmcfe_pkg::ADDR_CMD, v);
		wa(1'b1, 600);
		wa(1'b0, 4000);
	endtask
	task automatic sc(input logic [31:0] e);
		rc("status", mmcfe_pkg::ADDR_STATUS, e);
		wr(mmcfe_pkg::ADDR_CLEAR, e);
		rc("status after clear", mmcfe_pkg::ADDR_STATUS, 32'h0);
	endtask
	task automatic t_regs;
		rc("unmapped", 32'h700C_A0FC, 32'h0);
		wr(mmcfe_pkg::ADDR_RSTAT3, 32'hFFFF_FFFF);
		rc("read-only", mmcfe_pkg::ADDR_RSTAT3, 32'h0);
		for (int c = 0; c < 4; c++) begin
			wr(mmcfe_pkg::ADDR_POWER, 32'(c));
			chk("card_power_on", {31'h0, card_power_on}, {31'h0, c == 3});
			rc("power", mmcfe_pkg::ADDR_POWER, 32'(c));
		end
		$display("test regs done");
	endtask
	task automatic t_clock;
		cr(32'h0000_0102, 32'h8);
		cr(32'h0000_0500, 32'h18);
		cr(32'h0000_0002, 32'h0);
		cr(32'h0000_0B01, 32'h0);
		chk("four_line_select", {31'h0, four_line_select}, 32'h1);
		wr(mmcfe_pkg::ADDR_CLOCK, 32'h0000_0101);
		chk("four_line_select", {31'h0, four_line_select}, 32'h0);
		$display("test clock done");
	endtask
	task automatic t_cmd;
		mode <= 2'h0;
		// identification rate: divisor 31 keeps the card clock under the limit
		wr(mmcfe_pkg::ADDR_CLOCK, 32'h0000_011F);
		wr(mmcfe_pkg::ADDR_ARG, 32'hA5C3_0F12);
		cmd(32'h0000_042D);
		// the card takes the end bit half a period after the path goes idle
		repeat (64) @(posedge core_clk);
		chk("frame head", {24'h0, last_cmd[47:40]}, 32'h6D);
		chk("frame argument", last_cmd[39:8], 32'hA5C3_0F12);
		sc(32'h80);
		wr(mmcfe_pkg::ADDR_CLOCK, 32'h0000_0101);
		$display("test command done");
	endtask
	task automatic t_reply;
		mode <= 2'h1;
		cmd(32'h0000_0451);
		rc("reply index", mmcfe_pkg::ADDR_RINDEX, 32'h15);
		rc("short status", mmcfe_pkg::ADDR_RSTAT0, body[31:0]);
		sc(32'h40);
		mode <= 2'h2;
		cmd(32'h0000_04C2);
		rc("long index", mmcfe_pkg::ADDR_RINDEX, 32'h3F);
		for (int k = 0; k < 4; k++) begin
			d = body[127 - 32 * k -: 32];
			rc("long status", mmcfe_pkg::ADDR_RSTAT0 + 32'(4 * k), d & ~{31'h0, k == 3});
		end
		sc(32'h40);
		$display("test reply done");
	endtask
	task automatic t_wait;
		mode <= 2'h0;
		cmd(32'h0000_0446);
		sc(32'h04);
		wr(mmcfe_pkg::ADDR_CMD, 32'h0000_0546);
		repeat (600) @(posedge core_clk);
		rc("status", mmcfe_pkg::ADDR_STATUS, 32'h800);
		// enable has self-cleared by now, a write of zero must still stop the path
		wr(mmcfe_pkg::ADDR_CMD, 32'h0);
		rc("stopped", mmcfe_pkg::ADDR_STATUS, 32'h0);
		wr(mmcfe_pkg::ADDR_CMD, 32'h0000_0546);
		repeat (300) @(posedge core_clk);
		rc("irq wait", mmcfe_pkg::ADDR_STATUS, 32'h800);
		@(posedge core_clk);
		card_irq_seen <= 1'b1;
		wa(1'b0, 40);
		card_irq_seen <= 1'b0;
		f = frames;
		wr(mmcfe_pkg::ADDR_CMD, 32'h0000_060A);
		repeat (100) @(posedge core_clk);
		chk("frames while held", 32'(frames), 32'(f));
		command_go_input <= 1'b1;
		wa(1'b1, 40);
		wa(1'b0, 3000);
		// the card counts the frame at its last rising edge, after the path is idle
		repeat (8) @(posedge core_clk);
		chk("frames after go", 32'(frames), 32'(f + 1));
		sc(32'h80);
		$display("test wait done");
	endtask
	task automatic t_data;
		wr(mmcfe_pkg::ADDR_DTIMER, 32'h5);
		wr(mmcfe_pkg::ADDR_DLEN, 32'h0000_1234);
		rc("length", mmcfe_pkg::ADDR_DLEN, 32'h1234);
		wr(mmcfe_pkg::ADDR_DCTRL, 32'h1);
		chk("data_count_load", {16'h0, data_count_load}, 32'h1234);
		chk("data_direction", {31'h0, data_direction}, 32'h0);
		repeat (100) @(posedge core_clk);
		chk("timeout in send wait", {31'h0, data_timeout_flag}, 32'h0);
		data_busy <= 1'b1;
		repeat (100) @(posedge core_clk);
		chk("timeout in busy", {31'h0, data_timeout_flag}, 32'h1);
		data_busy <= 1'b0;
		// let the synchronised busy drop so no late timeout beats the clear
		repeat (4) @(posedge core_clk);
		wr(mmcfe_pkg::ADDR_CLEAR, 32'h08);
		wr(mmcfe_pkg::ADDR_DTIMER, 32'h20);
		wr(mmcfe_pkg::ADDR_DCTRL, 32'h3);
		chk("data_direction", {31'h0, data_direction}, 32'h1);
		chk("timeout early", {31'h0, data_timeout_flag}, 32'h0);
		repeat (200) @(posedge core_clk);
		chk("timeout in receive", {31'h0, data_timeout_flag}, 32'h1);
		$display("test data done");
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_regs;
		t_clock;
		t_cmd;
		t_reply;
		t_wait;
		t_data;
		tally_and_finish;
	end
endmodule
